// file: src/dct_countdown_unit.sv
`include "dct_map.svh"
`default_nettype none
module dct_countdown_unit
   import dct_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   dct_unit_if.unit bus
);
   logic [4:0] local_ofs;
   logic reg_hit, load_sel, value_sel, ctrl_sel, clear_sel, test_sel;
   logic wr_strobe, load_wr, ctrl_wr, test_wr, clear_wr;
   dct_word_t load_reg, count_reg, count_next, decremented_value;
   logic [1:0] ctrl_hi_reg, ctrl_lo_reg;
   logic test_mode_reg, load_pulse_reg;
   logic [3:0] nib_carry;
   logic msn_carry, rate_tick, counter_update_strobe, zero_hit;
   logic counter_input_choice, internal_zero_irq_reg, zero_irq_next;
   dct_rate_t rate_sel;

   assign local_ofs = {bus.paddr, 2'b00};
   assign reg_hit = bus.psel & bus.counter_select;
   assign load_sel = reg_hit & (local_ofs == `DCT_LOAD_OFS);
   assign value_sel = reg_hit & (local_ofs == `DCT_VALUE_OFS);
   assign ctrl_sel = reg_hit & (local_ofs == `DCT_CTRL_OFS);
   assign clear_sel = reg_hit & (local_ofs == `DCT_CLEAR_OFS);
   assign test_sel = reg_hit & (local_ofs == `DCT_TEST_OFS);
   assign bus.test_select = test_sel;
   assign wr_strobe = bus.psel & bus.penable & bus.pwrite;
   assign load_wr = load_sel & wr_strobe;
   assign ctrl_wr = ctrl_sel & wr_strobe;
   assign test_wr = test_sel & wr_strobe;
   assign clear_wr = clear_sel & wr_strobe;

   // Rate choice; the spare code falls back to full rate
   assign rate_sel = dct_rate_t'(ctrl_lo_reg);
   assign rate_tick = (rate_sel == DCT_RATE_DIV16) ? bus.div16_tick :
                      (rate_sel == DCT_RATE_DIV256) ? bus.div256_tick :
                      bus.full_rate_tick;
   assign counter_update_strobe = (rate_tick & ctrl_hi_reg[1]) |
                                  load_pulse_reg;

   // Test mode opens every carry so all nibbles loop on their own
   assign nib_carry[0] = 1'b1;
   for (genvar n = 1; n < 4; n++) begin : g_carry
      assign nib_carry[n] = test_mode_reg | (nib_carry[n-1] &
                            (count_reg[4*n-1 -: 4] == 4'h0));
   end
   for (genvar n = 0; n < 4; n++) begin : g_nib
      assign decremented_value[4*n+3 -: 4] = nib_carry[n] ?
         count_reg[4*n+3 -: 4] - 4'h1 : count_reg[4*n+3 -: 4];
   end
   assign msn_carry = (count_reg == 16'h0000);
   assign zero_hit = counter_update_strobe & msn_carry & ~load_pulse_reg;
   assign counter_input_choice = load_pulse_reg |
                                 (zero_hit & ctrl_hi_reg[0]);
   assign count_next = counter_input_choice ? load_reg :
                       decremented_value;
   // Set wins over a clear in the same cycle
   assign zero_irq_next = zero_hit |
                          (internal_zero_irq_reg & ~clear_wr);
   assign bus.zero_irq = internal_zero_irq_reg;

   assign bus.data_out = value_sel ? count_reg :
      load_sel ? load_reg :
      ctrl_sel ? {8'h00, ctrl_hi_reg, 2'b00, ctrl_lo_reg, 2'b00} :
      test_sel ? {14'h0000, bus.test_clock_choice, test_mode_reg} :
      clear_sel ? {15'h0000, internal_zero_irq_reg} :
      16'h0000;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         load_reg <= `DCT_LOAD_RST;
         ctrl_hi_reg <= `DCT_CTRL_RST;
         ctrl_lo_reg <= `DCT_CTRL_RST;
         test_mode_reg <= 1'b0;
      end else if (ce_i) begin
         if (load_wr) load_reg <= bus.pwdata;
         if (ctrl_wr) ctrl_hi_reg <= bus.pwdata[7:6];
         if (ctrl_wr) ctrl_lo_reg <= bus.pwdata[3:2];
         if (test_wr) test_mode_reg <= bus.pwdata[`DCT_TEST_MODE_BIT];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         load_pulse_reg <= 1'b0;
         count_reg <= `DCT_COUNT_RST;
         internal_zero_irq_reg <= 1'b0;
      end else if (ce_i) begin
         load_pulse_reg <= load_wr;
         if (counter_update_strobe) count_reg <= count_next;
         internal_zero_irq_reg <= zero_irq_next;
      end
   end

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);
   sequence s_load_write;
      load_wr && ce_i ##1 ce_i;
   endsequence
   chk_load_copy: assert property (s_load_write |=>
      count_reg == $past(bus.pwdata, 2)) else $error("load not copied");
   chk_irq_set: assert property (zero_hit && ce_i |=>
      internal_zero_irq_reg) else $error("zero did not set irq");
   chk_irq_hold: assert property (internal_zero_irq_reg && !clear_wr |=>
      internal_zero_irq_reg) else $error("irq lost");
   chk_periodic_reload: assert property (zero_hit && ctrl_hi_reg[0] && ce_i
      |=> count_reg == $past(load_reg))
      else $error("no reload");
   chk_free_wrap: assert property (zero_hit && !ctrl_hi_reg[0] && ce_i
      |=> count_reg == 16'hffff) else $error("no wrap");
   chk_test_loops: assert property (test_mode_reg && counter_update_strobe
      && !counter_input_choice && ce_i |=>
      count_reg[15:12] == $past(count_reg[15:12]) - 4'h1 &&
      count_reg[3:0] == $past(count_reg[3:0]) - 4'h1)
      else $error("nibbles not looping");
endmodule : dct_countdown_unit
`default_nettype wire

// file: src/dct_map.svh
`ifndef DCT_MAP_SVH
`define DCT_MAP_SVH

// Offsets within one counter's 32-byte window
`define DCT_LOAD_OFS 5'h00
`define DCT_VALUE_OFS 5'h04
`define DCT_CTRL_OFS 5'h08
`define DCT_CLEAR_OFS 5'h0c
`define DCT_TEST_OFS 5'h10
// Second counter window base
`define DCT_UNIT2_BASE 6'h20

// Control field positions
`define DCT_CTRL_ENABLE_BIT 7
`define DCT_CTRL_MODE_BIT 6
`define DCT_CTRL_RATE_HI 3
`define DCT_CTRL_RATE_LO 2

// Test field positions
`define DCT_TEST_MODE_BIT 0
`define DCT_TEST_CLK_BIT 1

// Reset values
`define DCT_LOAD_RST 16'h0000
`define DCT_COUNT_RST 16'h0000
`define DCT_CTRL_RST 2'h0
`define DCT_PRESCALE_RST 8'h00

// Prescaler tap bits for divide by 16 and divide by 256
`define DCT_TAP16 3
`define DCT_TAP256 7

`endif

// file: src/dct_pkg.sv
`default_nettype none
package dct_pkg;
   typedef logic [15:0] dct_word_t;
   typedef enum logic [1:0] {
      DCT_RATE_FULL,
      DCT_RATE_DIV16,
      DCT_RATE_DIV256,
      DCT_RATE_RSVD
   } dct_rate_t;
endpackage : dct_pkg
`default_nettype wire

// file: src/dct_timer.sv
`include "dct_map.svh"
`default_nettype none
module dct_timer
   import dct_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic ce_i,
   input wire logic timer_bus_select_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [5:2] paddr_i,
   input wire logic [15:0] pwdata_i,
   output logic [15:0] prdata_o,
   output logic prdata_oe_o,
   output logic first_timer_irq_o,
   output logic second_timer_irq_o
);

   dct_unit_if unit_one_if ();
   dct_unit_if unit_two_if ();

   logic [5:0] byte_addr;
   logic counter_one_select;
   logic counter_two_select;
   logic test_select;
   logic write_strobe;
   logic test_clock_write;

   logic test_clock_choice_reg;
   logic divider_tick_enable;
   logic [7:0] prescale_reg;
   logic [7:0] prescale_next;
   logic [1:0] tap_prev_reg;
   logic full_rate_tick_reg;
   logic div16_tick;
   logic div256_tick;
   logic [7:0] tick_gap_reg;

   dct_word_t read_word_comb;
   dct_word_t read_word_reg;
   logic read_drive_enable_next;
   logic read_drive_enable_reg;

   // Address decode
   assign byte_addr = {paddr_i, 2'b00};
   assign counter_one_select = timer_bus_select_i &
      (byte_addr[5] == 1'b0);
   assign counter_two_select = timer_bus_select_i &
      ((byte_addr & `DCT_UNIT2_BASE) == `DCT_UNIT2_BASE);
   // Local offset match hits both 0x10 and 0x30
   assign test_select = timer_bus_select_i &
      (byte_addr[4:0] == `DCT_TEST_OFS);
   assign write_strobe = timer_bus_select_i & penable_i & pwrite_i;
   assign test_clock_write = write_strobe & test_select;

   // Bus fan-out to both counters
   assign unit_one_if.counter_select = counter_one_select;
   assign unit_one_if.psel = timer_bus_select_i;
   assign unit_one_if.penable = penable_i;
   assign unit_one_if.pwrite = pwrite_i;
   assign unit_one_if.paddr = paddr_i[4:2];
   assign unit_one_if.pwdata = pwdata_i;
   assign unit_one_if.full_rate_tick = full_rate_tick_reg;
   assign unit_one_if.div16_tick = div16_tick;
   assign unit_one_if.div256_tick = div256_tick;
   assign unit_one_if.test_clock_choice = test_clock_choice_reg;

   assign unit_two_if.counter_select = counter_two_select;
   assign unit_two_if.psel = timer_bus_select_i;
   assign unit_two_if.penable = penable_i;
   assign unit_two_if.pwrite = pwrite_i;
   assign unit_two_if.paddr = paddr_i[4:2];
   assign unit_two_if.pwdata = pwdata_i;
   assign unit_two_if.full_rate_tick = full_rate_tick_reg;
   assign unit_two_if.div16_tick = div16_tick;
   assign unit_two_if.div256_tick = div256_tick;
   assign unit_two_if.test_clock_choice = test_clock_choice_reg;

   // Shared test clock select bit
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         test_clock_choice_reg <= 1'b0;
      end else if (ce_i && test_clock_write) begin
         test_clock_choice_reg <= pwdata_i[`DCT_TEST_CLK_BIT];
      end
   end

   // The test clock is modelled as an enable, not a gated clock,
   // so the whole block stays on one clock tree
   assign divider_tick_enable = test_clock_choice_reg ?
      (timer_bus_select_i & ~penable_i) : 1'b1;

   // Prescaler
   assign prescale_next = prescale_reg - 8'h01;

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         prescale_reg <= `DCT_PRESCALE_RST;
         tap_prev_reg <= 2'b00;
      end else if (ce_i && divider_tick_enable) begin
         prescale_reg <= prescale_next;
         tap_prev_reg <= {prescale_reg[`DCT_TAP256],
                          prescale_reg[`DCT_TAP16]};
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         full_rate_tick_reg <= 1'b0;
      end else if (ce_i) begin
         full_rate_tick_reg <= divider_tick_enable;
      end
   end

   // A tap rising on the down-count marks one wrap of its field,
   // so each divided tick is one full-rate tick wide
   assign div16_tick = full_rate_tick_reg &
      prescale_reg[`DCT_TAP16] & ~tap_prev_reg[0];
   assign div256_tick = full_rate_tick_reg &
      prescale_reg[`DCT_TAP256] & ~tap_prev_reg[1];

   // Checking aid: full-rate ticks since the last divide-by-256 tick
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         tick_gap_reg <= 8'hff;
      end else if (ce_i && full_rate_tick_reg) begin
         tick_gap_reg <= div256_tick ? 8'h00 : tick_gap_reg + 8'h01;
      end
   end

   // Counters
   dct_countdown_unit u_unit_one (
      .sys_clk_i (sys_clk_i),
      .srst_i (srst_i),
      .ce_i (ce_i),
      .bus (unit_one_if.unit)
   );

   dct_countdown_unit u_unit_two (
      .sys_clk_i (sys_clk_i),
      .srst_i (srst_i),
      .ce_i (ce_i),
      .bus (unit_two_if.unit)
   );

   assign first_timer_irq_o = unit_one_if.zero_irq;
   assign second_timer_irq_o = unit_two_if.zero_irq;

   // Read path
   assign read_word_comb = counter_two_select ? unit_two_if.data_out :
      counter_one_select ? unit_one_if.data_out : 16'h0000;
   assign read_drive_enable_next = timer_bus_select_i & penable_i &
      ~pwrite_i;

   // Registering the wide mux trades one cycle of latency for a
   // short path to the pins; it also samples the interrupt state
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         read_word_reg <= 16'h0000;
      end else if (ce_i && read_drive_enable_next) begin
         read_word_reg <= read_word_comb;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         read_drive_enable_reg <= 1'b0;
      end else if (ce_i) begin
         read_drive_enable_reg <= read_drive_enable_next;
      end
   end

   // Data reads zero while not driven; the pad resolves the bus
   assign prdata_o = read_drive_enable_reg ? read_word_reg : 16'h0000;
   assign prdata_oe_o = read_drive_enable_reg;

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);

   sequence s_read_access;
      timer_bus_select_i && penable_i && !pwrite_i && ce_i;
   endsequence

   sequence s_test_write;
      test_clock_write && ce_i;
   endsequence

   chk_full_copy: assert property (ce_i |=>
      full_rate_tick_reg == $past(divider_tick_enable))
      else $error("full-rate tick not a copy of enable");

   chk_normal_tick: assert property (!test_clock_choice_reg |->
      divider_tick_enable) else $error("enable dropped in normal mode");

   chk_test_tick: assert property (test_clock_choice_reg |->
      divider_tick_enable == (timer_bus_select_i && !penable_i))
      else $error("test tick wrong");

   chk_prescale_dec: assert property (ce_i && divider_tick_enable |=>
      prescale_reg == $past(prescale_reg) - 8'h01)
      else $error("prescaler not decremented");

   chk_div16_rate: assert property (div16_tick && ce_i |=>
      !div16_tick [*8]) else $error("div16 ticks too close");

   chk_div16_align: assert property (div16_tick |->
      full_rate_tick_reg && prescale_reg[3:0] == 4'hf)
      else $error("div16 tick misplaced");

   chk_div256_align: assert property (div256_tick |->
      div16_tick && prescale_reg == 8'hff)
      else $error("div256 tick misplaced");

   chk_read_drive: assert property (s_read_access |=>
      prdata_oe_o && prdata_o == $past(read_word_comb))
      else $error("read not driven");

   chk_read_quiet: assert property (!read_drive_enable_next && ce_i |=>
      !prdata_oe_o && prdata_o == 16'h0000)
      else $error("read driven outside a read");

   chk_clksel_write: assert property (s_test_write |=>
      test_clock_choice_reg == $past(pwdata_i[1]))
      else $error("test clock select not written");

   chk_div16_gap: assert property (div16_tick |->
      tick_gap_reg[3:0] == 4'hf) else $error("div16 tick early");

   chk_div16_due: assert property (full_rate_tick_reg &&
      tick_gap_reg[3:0] == 4'hf |-> div16_tick)
      else $error("div16 tick missing");

   chk_div256_gap: assert property (div256_tick |->
      tick_gap_reg == 8'hff) else $error("div256 tick early");

   chk_div256_due: assert property (full_rate_tick_reg &&
      tick_gap_reg == 8'hff |-> div256_tick)
      else $error("div256 tick missing");

   chk_unit_select: assert property (timer_bus_select_i |->
      counter_one_select != counter_two_select)
      else $error("counter selects not exclusive");

   chk_test_map: assert property (timer_bus_select_i &&
      (paddr_i == 4'h4 || paddr_i == 4'hc) |-> test_select)
      else $error("test location not decoded");

   chk_freeze: assert property (!ce_i |=>
      prescale_reg == $past(prescale_reg) &&
      read_drive_enable_reg == $past(read_drive_enable_reg))
      else $error("state moved while frozen");

   chk_read_hold: assert property (!read_drive_enable_next |=>
      $stable(read_word_reg)) else $error("read data changed");

   chk_clksel_hold: assert property (!test_clock_write |=>
      $stable(test_clock_choice_reg)) else $error("test clock select moved");

   chk_idle_no_tick: assert property (test_clock_choice_reg &&
      !timer_bus_select_i && ce_i |=> !full_rate_tick_reg)
      else $error("tick without an access");

   chk_read_unit_two: assert property (s_read_access &&
      counter_two_select |=> prdata_o == $past(unit_two_if.data_out))
      else $error("second counter read wrong");

   sequence s_write_access;
      timer_bus_select_i && penable_i && pwrite_i && ce_i;
   endsequence

   chk_write_quiet: assert property (s_write_access |=>
      !prdata_oe_o) else $error("write drove read data");

   sequence s_test_setup;
      test_clock_choice_reg && timer_bus_select_i && !penable_i && ce_i
      ##1 timer_bus_select_i && penable_i;
   endsequence

   chk_tick_access: assert property (s_test_setup |->
      full_rate_tick_reg) else $error("tick not aligned with access");

endmodule : dct_timer
`default_nettype wire

// file: src/dct_unit_if.sv
`default_nettype none
interface dct_unit_if;
   logic counter_select;
   logic psel;
   logic penable;
   logic pwrite;
   logic [4:2] paddr;
   logic [15:0] pwdata;
   logic full_rate_tick;
   logic div16_tick;
   logic div256_tick;
   logic test_clock_choice;
   logic [15:0] data_out;
   logic zero_irq;
   logic test_select;
   modport top (
      output counter_select, psel, penable, pwrite, paddr, pwdata,
      output full_rate_tick, div16_tick, div256_tick, test_clock_choice,
      input data_out, zero_irq, test_select
   );
   modport unit (
      input counter_select, psel, penable, pwrite, paddr, pwdata,
      input full_rate_tick, div16_tick, div256_tick, test_clock_choice,
      output data_out, zero_irq, test_select
   );
endinterface : dct_unit_if
`default_nettype wire

// file: testbench/dct_bridge_model.sv
`default_nettype none
module dct_bridge_model (
   input wire logic sys_clk_i,
   output logic sel_o,
   output logic penable_o,
   output logic pwrite_o,
   output logic [5:2] paddr_o,
   output logic [15:0] pwdata_o,
   input wire logic [15:0] prdata_i,
   input wire logic prdata_oe_i
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      sel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 4'h0;
      pwdata_o = 16'h0000;
   end

   // Called at a falling edge. The request is held after the access edge so
   // that a following access can start in the same step without a glitch.
   task automatic access(input logic wr, input logic [5:0] addr,
                         input logic [15:0] wdata,
                         output logic [15:0] rdata, output logic oe);
      sel_o = 1'b1;
      penable_o = 1'b0;
      pwrite_o = wr;
      paddr_o = addr[5:2];
      pwdata_o = wdata;
      @(negedge sys_clk_i);
      penable_o = 1'b1;
      @(negedge sys_clk_i);
      rdata = prdata_i;
      oe = prdata_oe_i;
   endtask : access

   // Released lines do not keep their last value
   task automatic idle();
      sel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = ~pwrite_o;
      paddr_o = ~paddr_o;
      pwdata_o = ~pwdata_o;
      @(negedge sys_clk_i);
   endtask : idle
endmodule : dct_bridge_model
`default_nettype wire

// file: testbench/dct_timer_test.sv
`default_nettype none
module dct_timer_test;
   timeunit 1ns;
   timeprecision 1ns;

   logic sys_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic ce = 1'b1;
   logic sel, pen, pwr, oe, irq1, irq2;
   logic [5:2] paddr;
   logic [15:0] pwdata, prdata;
   int errors = 0;
   int num_checks = 0;
   int cycles = 0;

   dct_timer i_dct_timer (
      .sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce),
      .timer_bus_select_i(sel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .prdata_oe_o(oe), .first_timer_irq_o(irq1),
      .second_timer_irq_o(irq2)
   );

   dct_bridge_model i_dct_bridge_model (
      .sys_clk_i(sys_clk_i), .sel_o(sel), .penable_o(pen), .pwrite_o(pwr),
      .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
      .prdata_oe_i(oe)
   );

   always #5 sys_clk_i = ~sys_clk_i;

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : stop_test

   // The run needs about 1200 cycles
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         errors++;
         stop_test();
      end
   end

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      logic [15:0] r;
      logic e;
      i_dct_bridge_model.access(1'b1, a, d, r, e);
      check("drive enable on write", {15'h0, e}, 16'h0000);
      check("data on write", r, 16'h0000);
   endtask : wr

   task automatic rd(input logic [5:0] a, output logic [15:0] r);
      logic e;
      i_dct_bridge_model.access(1'b0, a, 16'h0000, r, e);
      check("drive enable on read", {15'h0, e}, 16'h0001);
   endtask : rd

   task automatic rdc(input logic [5:0] a, input logic [15:0] exp);
      logic [15:0] r;
      rd(a, r);
      check($sformatf("read at %h", a), r, exp);
   endtask : rdc

   task automatic irqs(input logic e1, input logic e2);
      check("first irq", {15'h0, irq1}, {15'h0, e1});
      check("second irq", {15'h0, irq2}, {15'h0, e2});
   endtask : irqs

   task automatic t_reset();
      for (int i = 0; i < 10; i++) begin
         rdc(6'((i / 5) * 32 + (i % 5) * 4), 16'h0000);
      end
      i_dct_bridge_model.idle();
      irqs(1'b0, 1'b0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_regs();
      wr(6'h28, 16'h007f);
      rdc(6'h28, 16'h004c);
      wr(6'h00, 16'h1234);
      wr(6'h20, 16'habcd);
      wr(6'h04, 16'h5555);
      wr(6'h14, 16'hffff);
      rdc(6'h04, 16'h1234);
      rdc(6'h24, 16'habcd);
      rdc(6'h00, 16'h1234);
      rdc(6'h14, 16'h0000);
      wr(6'h28, 16'h0000);
      i_dct_bridge_model.idle();
      $display("test registers done");
   endtask : t_regs

   // With the test clock each access is one full-rate count
   task automatic t_periodic();
      wr(6'h10, 16'h0002);
      wr(6'h00, 16'h0002);
      wr(6'h08, 16'h00c0);
      rdc(6'h04, 16'h0002);
      rdc(6'h04, 16'h0001);
      rdc(6'h04, 16'h0000);
      rdc(6'h04, 16'h0002);
      irqs(1'b1, 1'b0);
      rdc(6'h0c, 16'h0001);
      wr(6'h0c, 16'h0000);
      irqs(1'b1, 1'b0);
      wr(6'h0c, 16'h0000);
      irqs(1'b0, 1'b0);
      wr(6'h08, 16'h0080);
      rdc(6'h04, 16'h0000);
      rdc(6'h04, 16'hffff);
      irqs(1'b1, 1'b0);
      wr(6'h08, 16'h0000);
      i_dct_bridge_model.idle();
      $display("test periodic done");
   endtask : t_periodic

   task automatic t_testmode();
      wr(6'h30, 16'h0003);
      rdc(6'h10, 16'h0002);
      rdc(6'h30, 16'h0003);
      wr(6'h20, 16'h1021);
      wr(6'h28, 16'h0080);
      rdc(6'h24, 16'h1021);
      rdc(6'h24, 16'h0f10);
      wr(6'h28, 16'h0000);
      wr(6'h30, 16'h0000);
      rdc(6'h10, 16'h0000);
      i_dct_bridge_model.idle();
      $display("test nibble mode done");
   endtask : t_testmode

   // Reads 256 cycles apart see the whole divider period
   task automatic t_rates();
      logic [15:0] v1, v2;
      logic [15:0] step [4] = '{16'h0100, 16'h0010, 16'h0001, 16'h0100};
      wr(6'h00, 16'hf000);
      for (int r = 0; r < 4; r++) begin
         wr(6'h08, 16'h0080 | 16'(r << 2));
         rd(6'h04, v1);
         i_dct_bridge_model.idle();
         repeat (253) @(negedge sys_clk_i);
         rd(6'h04, v2);
         check("count step", v1 - v2, step[r]);
      end
      wr(6'h08, 16'h0000);
      i_dct_bridge_model.idle();
      $display("test rates done");
   endtask : t_rates

   // Counter two would wrap past zero in four cycles unless the enable holds it
   task automatic t_freeze();
      wr(6'h20, 16'h0003);
      wr(6'h28, 16'h0080);
      ce = 1'b0;
      i_dct_bridge_model.idle();
      repeat (8) @(negedge sys_clk_i);
      check("second irq frozen", {15'h0, irq2}, 16'h0000);
      ce = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      irqs(1'b1, 1'b1);
      rdc(6'h24, 16'hfffe);
      rdc(6'h2c, 16'h0001);
      wr(6'h2c, 16'h0000);
      irqs(1'b1, 1'b0);
      wr(6'h28, 16'h0000);
      i_dct_bridge_model.idle();
      $display("test freeze done");
   endtask : t_freeze

   initial begin
      repeat (12) @(negedge sys_clk_i);
      srst_i = 1'b0;
      t_reset();
      t_regs();
      t_periodic();
      t_testmode();
      t_rates();
      t_freeze();
      stop_test();
   end
endmodule : dct_timer_test
`default_nettype wire
